//--- hw/ccrs_cc_class.sv
// classifies one cc line voltage as open, rd or ra for a dfp profile
module ccrs_cc_class (
  // inputs
  input wire ccrs_pkg::ccrs_prof_t i_prof,
  input wire ccrs_pkg::ccrs_mv_t i_mv,
  // result
  output ccrs_pkg::ccrs_cc_t o_class
);

  ccrs_pkg::ccrs_mv_t open_lo;
  ccrs_pkg::ccrs_mv_t rd_hi;
  ccrs_pkg::ccrs_mv_t rd_lo;
  ccrs_pkg::ccrs_mv_t ra_hi;

  always_comb begin
    case (i_prof)
      ccrs_pkg::PROF_3A: begin
        open_lo = ccrs_pkg::CC3A_OPEN_LO;
        rd_hi = ccrs_pkg::CC3A_RD_HI;
        rd_lo = ccrs_pkg::CC3A_RD_LO;
        ra_hi = ccrs_pkg::CC3A_RA_HI;
      end
      ccrs_pkg::PROF_1A5: begin
        open_lo = ccrs_pkg::CC1A5_OPEN_LO;
        rd_hi = ccrs_pkg::CC1A5_RD_HI;
        rd_lo = ccrs_pkg::CC1A5_RD_LO;
        ra_hi = ccrs_pkg::CC1A5_RA_HI;
      end
      default: begin
        open_lo = ccrs_pkg::CCLEG_OPEN_LO;
        rd_hi = ccrs_pkg::CCLEG_RD_HI;
        rd_lo = ccrs_pkg::CCLEG_RD_LO;
        ra_hi = ccrs_pkg::CCLEG_RA_HI;
      end
    endcase
  end

  // a line shorted to ground falls in the ra band
  always_comb begin
    if (i_mv >= open_lo) begin
      o_class = ccrs_pkg::CC_OPEN;
    end else if (i_mv <= rd_hi && i_mv >= rd_lo) begin
      o_class = ccrs_pkg::CC_RD;
    end else if (i_mv <= ra_hi) begin
      o_class = ccrs_pkg::CC_RA;
    end else begin
      // gaps between bands count as nothing attached
      o_class = ccrs_pkg::CC_UNDEF;
    end
  end

endmodule // ccrs_cc_class

//--- hw/ccrs_pkg.sv
// constants, types and carriers for the cc port role state machine
package ccrs_pkg;

  // analog inputs arrive as millivolt codes from the front-end converters
  localparam int MV_W = 13;
  typedef logic [MV_W-1:0] ccrs_mv_t;

  // configuration-select bands, millivolts
  localparam ccrs_mv_t CFG_3A_LO = 13'd1200;
  localparam ccrs_mv_t CFG_3A_HI = 13'd1300;
  localparam ccrs_mv_t CFG_1A5_LO = 13'd700;
  localparam ccrs_mv_t CFG_1A5_HI = 13'd800;
  localparam ccrs_mv_t CFG_LEG_HI = 13'd300;
  localparam ccrs_mv_t CFG_UFP_LO = 13'd1750;

  // dfp cc bands per profile: open floor, rd ceiling, rd floor, ra ceiling
  localparam ccrs_mv_t CC3A_OPEN_LO = 13'd2750;
  localparam ccrs_mv_t CC3A_RD_HI = 13'd2600;
  localparam ccrs_mv_t CC3A_RD_LO = 13'd850;
  localparam ccrs_mv_t CC3A_RA_HI = 13'd800;
  localparam ccrs_mv_t CC1A5_OPEN_LO = 13'd1650;
  localparam ccrs_mv_t CC1A5_RD_HI = 13'd1600;
  localparam ccrs_mv_t CC1A5_RD_LO = 13'd450;
  localparam ccrs_mv_t CC1A5_RA_HI = 13'd400;
  localparam ccrs_mv_t CCLEG_OPEN_LO = 13'd1650;
  localparam ccrs_mv_t CCLEG_RD_HI = 13'd1600;
  localparam ccrs_mv_t CCLEG_RD_LO = 13'd250;
  localparam ccrs_mv_t CCLEG_RA_HI = 13'd200;

  // ufp cc bands, millivolts
  localparam ccrs_mv_t UFP_LEG_LO = 13'd250;
  localparam ccrs_mv_t UFP_1A5_LO = 13'd700;
  localparam ccrs_mv_t UFP_3A_ABOVE = 13'd1310;

  // cycles after reset release before the power-on sample (sync depth)
  localparam logic [1:0] SAMPLE_DLY = 2'd2;

  typedef enum logic [1:0] {PROF_LEG, PROF_1A5, PROF_3A} ccrs_prof_t;
  typedef enum logic [1:0] {ROLE_NONE, ROLE_DFP, ROLE_UFP} ccrs_role_t;
  typedef enum logic [1:0] {CC_OPEN, CC_RD, CC_RA, CC_UNDEF} ccrs_cc_t;
  typedef enum logic [1:0] {CAP_NONE, CAP_LEG, CAP_1A5, CAP_3A} ccrs_cap_t;

  // dfp output pins travel together
  typedef struct packed {
    logic vbus_en;
    logic orient_n;
    logic line1_n;
    logic line2_n;
    logic audio;
  } ccrs_dfp_out_t;

  localparam ccrs_dfp_out_t DFP_OUT_IDLE = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b0};

endpackage

//--- hw/ccrs_sync.sv
// two-flop synchroniser for pin inputs
module ccrs_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_nrst,
  // data
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);

  logic [W-1:0] meta_reg;

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      meta_reg <= RST_VAL;
      o_q <= RST_VAL;
    end else begin
      meta_reg <= i_d;
      o_q <= meta_reg;
    end
  end

endmodule // ccrs_sync

//--- hw/ccrs_top.sv
// connection-detect and port role state machine for a reversible connector
// Operation
// - sample config select once at power-on
// - dfp bands pick 3a, 1.5a, legacy
// - ufp band; cc gives charging capability
// - classify each cc open, rd, ra
// - dfp profile follows live config select
// - role changes only through power-on reset
// - disabled or bad config: inactive outputs
// - enabled idle watches cc, outputs inactive
// - rd on cc1 only: supply on
// - rd cc1, ra cc2: line2 power on
// - rd on cc2 only: supply, orientation low
// - rd cc2, ra cc1: line1 power on
// - ra on both: audio indicator high
// - both lines grounded equals ra both
// - overcurrent forces defaults, fault flag high
// - cable power held until rd detaches
module ccrs_top (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_nrst,
  // analog front end, millivolt codes
  input wire ccrs_pkg::ccrs_mv_t i_cfg_sel_mv,
  input wire ccrs_pkg::ccrs_mv_t i_cc1_mv,
  input wire ccrs_pkg::ccrs_mv_t i_cc2_mv,
  // control pins
  input wire logic i_enable,
  input wire logic i_overcurrent_sense_n,
  // dfp outputs
  output logic o_vbus_supply_enable_out,
  output logic o_plug_orient_n,
  output logic o_cable_power_line1_n,
  output logic o_cable_power_line2_n,
  output logic o_audio_adapter,
  // status outputs
  output logic o_fault_flag_out,
  output logic o_role_ufp,
  output ccrs_pkg::ccrs_cap_t o_ufp_cap
);

  typedef enum logic [3:0] {
    S_DISABLED, S_EN_IDLE, S_UNFLIP_PASSIVE, S_UNFLIP_ACTIVE,
    S_FLIP_PASSIVE, S_FLIP_ACTIVE, S_AUDIO, S_FAULT, S_UFP
  } ccrs_state_t;

  ccrs_pkg::ccrs_mv_t cfg_s, cc1_s, cc2_s;
  logic en_s, ocs_n_s, en_d_reg, en_fall;
  logic [1:0] por_cnt_reg;
  logic sampled_reg;
  ccrs_pkg::ccrs_role_t role_reg;
  ccrs_pkg::ccrs_prof_t prof;
  logic cfg_dfp_ok;
  logic active;
  ccrs_pkg::ccrs_cc_t c1, c2;
  ccrs_state_t state_reg, state_next, fresh;
  ccrs_pkg::ccrs_dfp_out_t out_next;
  ccrs_pkg::ccrs_cap_t cap_next;

  // pins from outside the clock domain
  ccrs_sync #(.W(3 * ccrs_pkg::MV_W), .RST_VAL('0)) u_sync_mv (
    .i_sys_clk(i_sys_clk),
    .i_nrst(i_nrst),
    .i_d({i_cfg_sel_mv, i_cc1_mv, i_cc2_mv}),
    .o_q({cfg_s, cc1_s, cc2_s})
  );

  // overcurrent idles high so reset does not fake a fault
  ccrs_sync #(.W(2), .RST_VAL(2'b01)) u_sync_pin (
    .i_sys_clk(i_sys_clk),
    .i_nrst(i_nrst),
    .i_d({i_enable, i_overcurrent_sense_n}),
    .o_q({en_s, ocs_n_s})
  );

  // power-on sample, once the synchronisers hold real pin values
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      por_cnt_reg <= '0;
      sampled_reg <= 1'b0;
      role_reg <= ccrs_pkg::ROLE_NONE;
    end else if (!sampled_reg) begin
      if (por_cnt_reg == ccrs_pkg::SAMPLE_DLY) begin
        sampled_reg <= 1'b1;
        if (cfg_s >= ccrs_pkg::CFG_UFP_LO) begin
          role_reg <= ccrs_pkg::ROLE_UFP;
        end else if (cfg_dfp_ok) begin
          role_reg <= ccrs_pkg::ROLE_DFP;
        end
      end else begin
        por_cnt_reg <= por_cnt_reg + 2'd1;
      end
    end
  end

  // live profile decode; role is never revisited here
  always_comb begin
    cfg_dfp_ok = 1'b1;
    if (cfg_s >= ccrs_pkg::CFG_3A_LO && cfg_s <= ccrs_pkg::CFG_3A_HI) begin
      prof = ccrs_pkg::PROF_3A;
    end else if (cfg_s >= ccrs_pkg::CFG_1A5_LO && cfg_s <= ccrs_pkg::CFG_1A5_HI) begin
      prof = ccrs_pkg::PROF_1A5;
    end else if (cfg_s <= ccrs_pkg::CFG_LEG_HI) begin
      prof = ccrs_pkg::PROF_LEG;
    end else begin
      prof = ccrs_pkg::PROF_LEG;
      cfg_dfp_ok = 1'b0;
    end
  end

  assign active = en_s && cfg_dfp_ok && role_reg == ccrs_pkg::ROLE_DFP;

  ccrs_cc_class u_cls_cc1 (
    .i_prof(prof),
    .i_mv(cc1_s),
    .o_class(c1)
  );

  ccrs_cc_class u_cls_cc2 (
    .i_prof(prof),
    .i_mv(cc2_s),
    .o_class(c2)
  );

  // attach decision from the present cc picture
  always_comb begin
    if (c1 == ccrs_pkg::CC_RA && c2 == ccrs_pkg::CC_RA) begin
      fresh = S_AUDIO;
    end else if (c1 == ccrs_pkg::CC_RD && c2 == ccrs_pkg::CC_RA) begin
      fresh = S_UNFLIP_ACTIVE;
    end else if (c2 == ccrs_pkg::CC_RD && c1 == ccrs_pkg::CC_RA) begin
      fresh = S_FLIP_ACTIVE;
    end else if (c1 == ccrs_pkg::CC_RD && c2 != ccrs_pkg::CC_RD) begin
      fresh = S_UNFLIP_PASSIVE;
    end else if (c2 == ccrs_pkg::CC_RD && c1 != ccrs_pkg::CC_RD) begin
      fresh = S_FLIP_PASSIVE;
    end else begin
      // rd on both lines is no legal attach
      fresh = S_EN_IDLE;
    end
  end

  always_comb begin
    state_next = fresh;
    if (!ocs_n_s) begin
      state_next = S_FAULT;
    end else if (role_reg == ccrs_pkg::ROLE_UFP) begin
      state_next = S_UFP;
    end else if (!active) begin
      state_next = S_DISABLED;
    end else begin
      case (state_reg)
        // line power stays until the rd side goes away
        S_UNFLIP_ACTIVE: begin
          if (c1 == ccrs_pkg::CC_RD) begin
            state_next = S_UNFLIP_ACTIVE;
          end
        end
        S_FLIP_ACTIVE: begin
          if (c2 == ccrs_pkg::CC_RD) begin
            state_next = S_FLIP_ACTIVE;
          end
        end
        default: state_next = fresh;
      endcase
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state_reg <= S_DISABLED;
    end else begin
      state_reg <= state_next;
    end
  end

  // output pattern for the state being entered
  always_comb begin
    out_next = ccrs_pkg::DFP_OUT_IDLE;
    case (state_next)
      S_UNFLIP_PASSIVE: begin
        out_next.vbus_en = 1'b1;
      end
      S_UNFLIP_ACTIVE: begin
        out_next.vbus_en = 1'b1;
        out_next.line2_n = 1'b0;
      end
      S_FLIP_PASSIVE: begin
        out_next.vbus_en = 1'b1;
        out_next.orient_n = 1'b0;
      end
      S_FLIP_ACTIVE: begin
        out_next.vbus_en = 1'b1;
        out_next.orient_n = 1'b0;
        out_next.line1_n = 1'b0;
      end
      S_AUDIO: begin
        out_next.audio = 1'b1;
      end
      default: out_next = ccrs_pkg::DFP_OUT_IDLE;
    endcase
  end

  // ufp capability from whichever line carries the pull-up
  always_comb begin
    ccrs_pkg::ccrs_mv_t mv;
    mv = (cc1_s >= cc2_s) ? cc1_s : cc2_s;
    if (state_next != S_UFP || mv < ccrs_pkg::UFP_LEG_LO) begin
      cap_next = ccrs_pkg::CAP_NONE;
    end else if (mv < ccrs_pkg::UFP_1A5_LO) begin
      cap_next = ccrs_pkg::CAP_LEG;
    end else if (mv <= ccrs_pkg::UFP_3A_ABOVE) begin
      cap_next = ccrs_pkg::CAP_1A5;
    end else begin
      cap_next = ccrs_pkg::CAP_3A;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_vbus_supply_enable_out <= 1'b0;
      o_plug_orient_n <= 1'b1;
      o_cable_power_line1_n <= 1'b1;
      o_cable_power_line2_n <= 1'b1;
      o_audio_adapter <= 1'b0;
      o_ufp_cap <= ccrs_pkg::CAP_NONE;
      o_role_ufp <= 1'b0;
    end else begin
      o_vbus_supply_enable_out <= out_next.vbus_en;
      o_plug_orient_n <= out_next.orient_n;
      o_cable_power_line1_n <= out_next.line1_n;
      o_cable_power_line2_n <= out_next.line2_n;
      o_audio_adapter <= out_next.audio;
      o_ufp_cap <= cap_next;
      o_role_ufp <= role_reg == ccrs_pkg::ROLE_UFP;
    end
  end

  // fault flag: sticky until enable falls; a new fault beats the clear
  assign en_fall = en_d_reg && !en_s;

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      en_d_reg <= 1'b0;
      o_fault_flag_out <= 1'b0;
    end else begin
      en_d_reg <= en_s;
      if (!ocs_n_s) begin
        o_fault_flag_out <= 1'b1;
      end else if (en_fall) begin
        o_fault_flag_out <= 1'b0;
      end
    end
  end

  property p_fault_defaults;
    @(posedge i_sys_clk) disable iff (!i_nrst)
      !ocs_n_s |=> o_fault_flag_out && !o_vbus_supply_enable_out && !o_audio_adapter
        && o_cable_power_line1_n && o_cable_power_line2_n && state_reg == S_FAULT;
  endproperty
  a_fault_defaults: assert property (p_fault_defaults)
    else $error("overcurrent did not force defaults");
  property p_fault_sticky;
    @(posedge i_sys_clk) disable iff (!i_nrst)
      o_fault_flag_out && !en_fall |=> o_fault_flag_out;
  endproperty
  a_fault_sticky: assert property (p_fault_sticky)
    else $error("fault flag dropped without enable toggle");
  property p_role_fixed;
    @(posedge i_sys_clk) disable iff (!i_nrst)
      sampled_reg |=> $stable(role_reg) && sampled_reg;
  endproperty
  a_role_fixed: assert property (p_role_fixed)
    else $error("role changed after power-on sample");
  property p_disabled;
    @(posedge i_sys_clk) disable iff (!i_nrst)
      (!en_s || !cfg_dfp_ok) && role_reg == ccrs_pkg::ROLE_DFP |=> state_reg != S_EN_IDLE
        && !o_vbus_supply_enable_out && o_plug_orient_n && !o_audio_adapter;
  endproperty
  a_disabled: assert property (p_disabled)
    else $error("inactive port drove an output");
  property p_idle;
    @(posedge i_sys_clk) disable iff (!i_nrst)
      state_reg == S_EN_IDLE |-> !o_vbus_supply_enable_out && o_plug_orient_n
        && o_cable_power_line1_n && o_cable_power_line2_n && !o_audio_adapter;
  endproperty
  a_idle: assert property (p_idle)
    else $error("enabled idle outputs wrong");
  property p_unflip_passive;
    @(posedge i_sys_clk) disable iff (!i_nrst)
      active && ocs_n_s && state_reg != S_UNFLIP_ACTIVE && c1 == ccrs_pkg::CC_RD
        && c2 == ccrs_pkg::CC_OPEN |=> o_vbus_supply_enable_out && o_plug_orient_n
        && o_cable_power_line2_n;
  endproperty
  a_unflip_passive: assert property (p_unflip_passive)
    else $error("cc1 rd attach outputs wrong");
  property p_unflip_active;
    @(posedge i_sys_clk) disable iff (!i_nrst)
      state_reg == S_UNFLIP_ACTIVE |-> o_vbus_supply_enable_out && !o_cable_power_line2_n
        && o_cable_power_line1_n && o_plug_orient_n;
  endproperty
  a_unflip_active: assert property (p_unflip_active)
    else $error("unflipped active cable outputs wrong");
  property p_flip_passive;
    @(posedge i_sys_clk) disable iff (!i_nrst)
      active && ocs_n_s && state_reg != S_FLIP_ACTIVE && c2 == ccrs_pkg::CC_RD
        && c1 == ccrs_pkg::CC_OPEN |=> o_vbus_supply_enable_out && !o_plug_orient_n
        && o_cable_power_line1_n;
  endproperty
  a_flip_passive: assert property (p_flip_passive)
    else $error("cc2 rd attach outputs wrong");
  property p_flip_active;
    @(posedge i_sys_clk) disable iff (!i_nrst)
      state_reg == S_FLIP_ACTIVE |-> o_vbus_supply_enable_out && !o_plug_orient_n
        && !o_cable_power_line1_n && o_cable_power_line2_n;
  endproperty
  a_flip_active: assert property (p_flip_active)
    else $error("flipped active cable outputs wrong");
  property p_audio;
    @(posedge i_sys_clk) disable iff (!i_nrst)
      active && ocs_n_s && c1 == ccrs_pkg::CC_RA && c2 == ccrs_pkg::CC_RA
        |=> o_audio_adapter && !o_vbus_supply_enable_out && state_reg == S_AUDIO;
  endproperty
  a_audio: assert property (p_audio)
    else $error("audio adapter not taken first");
  property p_line_hold;
    @(posedge i_sys_clk) disable iff (!i_nrst)
      state_reg == S_UNFLIP_ACTIVE && active && ocs_n_s && c1 == ccrs_pkg::CC_RD
        |=> !o_cable_power_line2_n;
  endproperty
  a_line_hold: assert property (p_line_hold)
    else $error("line power dropped while rd present");

endmodule // ccrs_top

//--- tb/ccrs_cable_model.sv
// behavioural model of the cable, device or adapter on the two cc lines
module ccrs_cable_model (
  // what is attached
  input wire ccrs_pkg::ccrs_prof_t i_prof,
  input wire ccrs_pkg::ccrs_cc_t i_att1,
  input wire ccrs_pkg::ccrs_cc_t i_att2,
  input wire logic i_gnd_short,
  input wire logic i_ufp,
  input wire ccrs_pkg::ccrs_mv_t i_rp_mv,
  // line voltages
  output ccrs_pkg::ccrs_mv_t o_cc1_mv,
  output ccrs_pkg::ccrs_mv_t o_cc2_mv
);
  timeunit 1ns;
  timeprecision 1ps;

  // mid-band levels per profile; undef lands in the gap between rd and ra
  function automatic ccrs_pkg::ccrs_mv_t line_mv(input ccrs_pkg::ccrs_prof_t p,
                                                 input ccrs_pkg::ccrs_cc_t a);
    logic h;
    h = (p == ccrs_pkg::PROF_3A);
    case (a)
      ccrs_pkg::CC_OPEN: line_mv = 13'h1388;
      ccrs_pkg::CC_RD: line_mv = h ? 13'h06a4 : 13'h03e8;
      ccrs_pkg::CC_RA: line_mv = h ? 13'h0190 : (p == ccrs_pkg::PROF_1A5) ? 13'h00c8 : 13'h0064;
      default: line_mv = h ? 13'h0339 : (p == ccrs_pkg::PROF_1A5) ? 13'h01a9 : 13'h00e1;
    endcase
  endfunction

  // a real audio adapter just grounds both lines
  always_comb begin
    if (i_gnd_short) begin
      o_cc1_mv = 13'h0000;
      o_cc2_mv = 13'h0000;
    end else if (i_ufp) begin
      o_cc1_mv = i_rp_mv;
      o_cc2_mv = 13'h0000;
    end else begin
      o_cc1_mv = line_mv(i_prof, i_att1);
      o_cc2_mv = line_mv(i_prof, i_att2);
    end
  end
endmodule // ccrs_cable_model

//--- tb/ccrs_top_test.sv
// self-checking bench for the cc port role state machine
module ccrs_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam ccrs_pkg::ccrs_mv_t V_3A = 13'h04e2;
  localparam ccrs_pkg::ccrs_mv_t V_1A5 = 13'h02ee;
  localparam ccrs_pkg::ccrs_mv_t V_LEG = 13'h0096;
  localparam ccrs_pkg::ccrs_mv_t V_UFP = 13'h07d0;
  localparam ccrs_pkg::ccrs_mv_t V_BAD = 13'h03e8;
  localparam ccrs_pkg::ccrs_dfp_out_t IDLE = ccrs_pkg::DFP_OUT_IDLE;
  localparam ccrs_pkg::ccrs_dfp_out_t E_RD1 = 5'h1e;
  localparam ccrs_pkg::ccrs_dfp_out_t E_ACT1 = 5'h1c;
  localparam ccrs_pkg::ccrs_dfp_out_t E_RD2 = 5'h16;
  localparam ccrs_pkg::ccrs_dfp_out_t E_ACT2 = 5'h12;
  localparam ccrs_pkg::ccrs_dfp_out_t E_AUD = 5'h0f;
  localparam ccrs_pkg::ccrs_cc_t OP = ccrs_pkg::CC_OPEN;
  localparam ccrs_pkg::ccrs_cc_t RD = ccrs_pkg::CC_RD;
  localparam ccrs_pkg::ccrs_cc_t RA = ccrs_pkg::CC_RA;
  localparam ccrs_pkg::ccrs_cc_t UD = ccrs_pkg::CC_UNDEF;
  localparam ccrs_pkg::ccrs_cc_t T1 [8] = '{OP, RD, RD, RD, OP, RA, RA, RD};
  localparam ccrs_pkg::ccrs_cc_t T2 [8] = '{OP, OP, RA, UD, RD, RD, RA, RD};
  localparam ccrs_pkg::ccrs_dfp_out_t TE [8] =
    '{IDLE, E_RD1, E_ACT1, E_RD1, E_RD2, E_ACT2, E_AUD, IDLE};

  logic i_sys_clk, i_nrst, enable, ocs_n, gnd, ufp;
  ccrs_pkg::ccrs_mv_t cfg_mv, rp_mv, cc1_mv, cc2_mv;
  ccrs_pkg::ccrs_prof_t prof;
  ccrs_pkg::ccrs_cc_t att1, att2;
  logic vbus, orient_n, l1_n, l2_n, audio, fault, role_ufp;
  ccrs_pkg::ccrs_cap_t cap;
  ccrs_pkg::ccrs_dfp_out_t outs;
  int error_cnt = 0;
  int n_checks = 0;

  assign outs = {vbus, orient_n, l1_n, l2_n, audio};

  ccrs_cable_model u_cable (.i_prof(prof), .i_att1(att1), .i_att2(att2), .i_gnd_short(gnd),
    .i_ufp(ufp), .i_rp_mv(rp_mv), .o_cc1_mv(cc1_mv), .o_cc2_mv(cc2_mv));

  ccrs_top dut (.i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .i_cfg_sel_mv(cfg_mv),
    .i_cc1_mv(cc1_mv), .i_cc2_mv(cc2_mv), .i_enable(enable), .i_overcurrent_sense_n(ocs_n),
    .o_vbus_supply_enable_out(vbus), .o_plug_orient_n(orient_n),
    .o_cable_power_line1_n(l1_n), .o_cable_power_line2_n(l2_n), .o_audio_adapter(audio),
    .o_fault_flag_out(fault), .o_role_ufp(role_ufp), .o_ufp_cap(cap));

  initial begin
    i_sys_clk = 1'b0;
    forever #5 i_sys_clk = ~i_sys_clk;
  end

  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_out(input ccrs_pkg::ccrs_dfp_out_t exp);
    chk({3'h0, outs}, {3'h0, exp});
  endtask

  // three edges of latency; two spare so sampling never meets the update
  task automatic settle();
    repeat (5) @(posedge i_sys_clk);
    #1;
  endtask

  task automatic set_cc(input ccrs_pkg::ccrs_cc_t a1, input ccrs_pkg::ccrs_cc_t a2);
    @(posedge i_sys_clk);
    att1 <= a1;
    att2 <= a2;
    settle();
  endtask

  task automatic set_cfg(input ccrs_pkg::ccrs_mv_t v, input ccrs_pkg::ccrs_prof_t p);
    @(posedge i_sys_clk);
    cfg_mv <= v;
    prof <= p;
    settle();
  endtask

  task automatic set_pins(input logic en, input logic oc);
    @(posedge i_sys_clk);
    enable <= en;
    ocs_n <= oc;
    settle();
  endtask

  // pins stay still for several edges after release so the role sample is clean
  task automatic do_reset(input ccrs_pkg::ccrs_mv_t v, input ccrs_pkg::ccrs_prof_t p);
    @(posedge i_sys_clk);
    i_nrst <= 1'b0;
    cfg_mv <= v;
    prof <= p;
    repeat (12) @(posedge i_sys_clk);
    i_nrst <= 1'b1;
    repeat (6) @(posedge i_sys_clk);
    #1;
  endtask

  task automatic t_inactive();
    do_reset(V_3A, ccrs_pkg::PROF_3A);
    chk({7'h0, role_ufp}, 8'h00);
    set_cc(RD, OP);
    chk_out(IDLE);
    set_pins(1'b1, 1'b1);
    chk_out(E_RD1);
    set_cfg(V_BAD, ccrs_pkg::PROF_3A);
    chk_out(IDLE);
    set_cfg(V_3A, ccrs_pkg::PROF_3A);
    chk_out(E_RD1);
    set_pins(1'b0, 1'b1);
    chk_out(IDLE);
    set_pins(1'b1, 1'b1);
    set_cc(OP, OP);
    $display("test inactive done");
  endtask

  task automatic t_table();
    ccrs_pkg::ccrs_prof_t pl [3];
    ccrs_pkg::ccrs_mv_t vl [3];
    pl = '{ccrs_pkg::PROF_3A, ccrs_pkg::PROF_1A5, ccrs_pkg::PROF_LEG};
    vl = '{V_3A, V_1A5, V_LEG};
    for (int p = 0; p < 3; p++) begin
      set_cfg(vl[p], pl[p]);
      for (int k = 0; k < 8; k++) begin
        set_cc(T1[k], T2[k]);
        chk_out(TE[k]);
        chk({6'h0, cap}, 8'h00);
        set_cc(OP, OP);
      end
    end
    // a 3a-profile rd level reads as open under the 1.5a bands
    set_cfg(V_3A, ccrs_pkg::PROF_3A);
    set_cc(RD, OP);
    set_cfg(V_1A5, ccrs_pkg::PROF_3A);
    chk_out(IDLE);
    set_cfg(V_3A, ccrs_pkg::PROF_3A);
    chk_out(E_RD1);
    set_cc(OP, OP);
    $display("test table done");
  endtask

  task automatic t_gnd_hold();
    @(posedge i_sys_clk);
    gnd <= 1'b1;
    settle();
    chk_out(E_AUD);
    @(posedge i_sys_clk);
    gnd <= 1'b0;
    settle();
    chk_out(IDLE);
    set_cc(RD, RA);
    chk_out(E_ACT1);
    set_cc(RD, OP);
    chk_out(E_ACT1);
    set_cc(OP, OP);
    chk_out(IDLE);
    set_cc(RA, RD);
    chk_out(E_ACT2);
    set_cc(OP, RD);
    chk_out(E_ACT2);
    set_cc(OP, OP);
    chk_out(IDLE);
    $display("test ground and hold done");
  endtask

  task automatic t_fault();
    set_cc(RD, OP);
    set_pins(1'b1, 1'b0);
    chk_out(IDLE);
    chk({7'h0, fault}, 8'h01);
    set_pins(1'b1, 1'b1);
    chk_out(E_RD1);
    chk({7'h0, fault}, 8'h01);
    set_pins(1'b0, 1'b1);
    chk({7'h0, fault}, 8'h00);
    chk_out(IDLE);
    set_pins(1'b1, 1'b1);
    set_cc(OP, OP);
    $display("test fault done");
  endtask

  task automatic t_roles();
    ccrs_pkg::ccrs_mv_t rl [5];
    logic [1:0] el [5];
    rl = '{13'h0064, 13'h01f4, 13'h03e8, 13'h051e, 13'h07d0};
    el = '{2'h0, 2'h1, 2'h2, 2'h2, 2'h3};
    do_reset(V_UFP, ccrs_pkg::PROF_3A);
    chk({7'h0, role_ufp}, 8'h01);
    @(posedge i_sys_clk);
    ufp <= 1'b1;
    for (int k = 0; k < 5; k++) begin
      @(posedge i_sys_clk);
      rp_mv <= rl[k];
      settle();
      chk({6'h0, cap}, {6'h0, el[k]});
    end
    @(posedge i_sys_clk);
    ufp <= 1'b0;
    att1 <= RD;
    settle();
    set_cfg(V_3A, ccrs_pkg::PROF_3A);
    chk({7'h0, role_ufp}, 8'h01);
    chk_out(IDLE);
    do_reset(V_3A, ccrs_pkg::PROF_3A);
    chk({7'h0, role_ufp}, 8'h00);
    chk_out(E_RD1);
    set_cfg(V_UFP, ccrs_pkg::PROF_3A);
    chk({7'h0, role_ufp}, 8'h00);
    chk_out(IDLE);
    $display("test roles done");
  endtask

  // no run may hang past this bound
  initial begin
    repeat (20000) @(posedge i_sys_clk);
    error_cnt++;
    $display("[FAIL] t=%0t got=%h exp=%h", $time, 8'h00, 8'h01);
    finish_test();
  end

  initial begin
    i_nrst = 1'b0;
    enable = 1'b0;
    ocs_n = 1'b1;
    gnd = 1'b0;
    ufp = 1'b0;
    rp_mv = 13'h0000;
    cfg_mv = V_3A;
    prof = ccrs_pkg::PROF_3A;
    att1 = OP;
    att2 = OP;
    t_inactive();
    t_table();
    t_gnd_hold();
    t_fault();
    t_roles();
    finish_test();
  end
endmodule // ccrs_top_test
